// [design/mbng_pkg.sv]
// mux bus nic glue: shared types, states and constants
package mbng_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int AD_W        = 32;
   localparam int WIN_BYTES   = 256;
   localparam int WORD_BYTES  = 4;
   localparam int REG_IDX_W   = $clog2(WIN_BYTES / WORD_BYTES);
   localparam int REG_IDX_LSB = $clog2(WORD_BYTES);
   localparam int WIN_LSB     = $clog2(WIN_BYTES);
   localparam int BASE_W      = AD_W - WIN_LSB;

   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam logic [1:0] SLAVE_ACCESS_DONE_TO_ACK  = 2'h2;
   localparam logic [1:0] ACK_CNT_START = 2'h1;
   localparam logic [1:0] ACK_CNT_LAST  = SLAVE_ACCESS_DONE_TO_ACK - 2'h1;

   // ----------------------------------------------------------------
   // pin groups
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic            ale;
      logic            dataPhaseN;
      logic            rdN;
      logic            wrN;
      logic            holdGrantN;
   } mbng_host_in_t;

   typedef struct packed {
      logic addrStrobeN;
      logic slaveDoneN;
      logic busRequestN;
      logic grantTakenN;
      logic direction;
   } mbng_nic_in_t;

   typedef struct packed {
      logic writeAckN;
      logic readValidN;
      logic holdRequestN;
      logic aleOut;
      logic dataPhaseOutN;
      logic dataPhaseOe;
      logic rdOutN;
      logic wrOutN;
      logic strobeOe;
   } mbng_host_out_t;

   typedef struct packed {
      logic                 chipSelN;
      logic                 slaveAddrStrobeN;
      logic                 grantInN;
      logic [REG_IDX_W-1:0] regAddr;
   } mbng_nic_out_t;

   typedef struct packed {
      logic addrToBus;
      logic nicToBus;
      logic busToNic;
   } mbng_buf_oe_t;

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SLV_IDLE = 4'h1,
      SLV_SEL  = 4'h2,
      SLV_WAIT = 4'h4,
      SLV_ACK  = 4'h8
   } mbng_slave_e_t;

   typedef enum logic [3:0] {
      MST_IDLE = 4'h1,
      MST_T1   = 4'h2,
      MST_ALE  = 4'h4,
      MST_DATA = 4'h8
   } mbng_master_e_t;

   typedef struct packed {
      mbng_host_in_t        hostS1;
      mbng_host_in_t        hostS2;
      mbng_nic_in_t         nicS1;
      mbng_nic_in_t         nicS2;
      logic                 alePrev;
      logic                 captured;
      logic                 windowHit;
      logic [REG_IDX_W-1:0] regAddr;
      mbng_slave_e_t        slv;
      logic [1:0]           ackCnt;
      logic                 isRead;
      mbng_master_e_t       mst;
      logic                 holdReq;
      logic                 grantIn;
   } mbng_state_t;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam mbng_host_in_t HOST_IN_IDLE = '{ad: '0, ale: 1'b0, dataPhaseN: 1'b1,
      rdN: 1'b1, wrN: 1'b1, holdGrantN: 1'b1};
   localparam mbng_nic_in_t NIC_IN_IDLE = '{addrStrobeN: 1'b1, slaveDoneN: 1'b1,
      busRequestN: 1'b1, grantTakenN: 1'b1, direction: 1'b0};
   localparam mbng_state_t STATE_RST = '{hostS1: HOST_IN_IDLE, hostS2: HOST_IN_IDLE,
      nicS1: NIC_IN_IDLE, nicS2: NIC_IN_IDLE, alePrev: 1'b0, captured: 1'b0,
      windowHit: 1'b0, regAddr: '0, slv: SLV_IDLE, ackCnt: 2'h0, isRead: 1'b0,
      mst: MST_IDLE, holdReq: 1'b0, grantIn: 1'b0};

endpackage : mbng_pkg

// [design/mbng_glue.sv]
// mux bus nic glue: slave window, bus request and master steering logic
//
// Operation
// - controller appears as a relocatable 256-byte window of 32-bit words
// - a register access through the glue takes roughly seven bus clocks
// - as owner, controller does 32-bit DMA transfers of three bus clocks
// - controller wins bus ownership from the host before any DMA
// - address buffers drive only when owner, address strobe and master ALE
// - address buffers stay off in the data phase of master transfers
// - register address latch follows the bus while host ALE is high
// - slave read data drives the bus only after host data phase asserts
// - master write data drives the bus only after master ALE drops
// - bus-to-controller buffer opens for slave writes and master reads in data phase
// - host ALE fall captures decode result and register address
// - window hit asserts when latched address decodes to the window
// - next edge copies window hit onto chip select and slave strobe
// - write ack or read valid asserts two clocks after slave done
// - write ack and read valid last exactly one clock
// - dropping ack or read valid also drops chip select and slave strobe
// - controller bus request reaches host hold request through a register
// - host hold grant is passed on to controller grant input
// - hold request is bus request OR grant taken
// - master ALE asserts in the second cycle of a master access
// - master read or write strobe spans address strobe to last cycle
`timescale 1ns/10ps
`default_nettype none

module mbng_glue
   import mbng_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic [BASE_W-1:0] windowBase,
   input  wire mbng_host_in_t     hostIn,
   input  wire mbng_nic_in_t      nicIn,
   output var  mbng_host_out_t    hostOut,
   output var  mbng_nic_out_t     nicOut,
   output var  mbng_buf_oe_t      bufOe
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   mbng_state_t q;
   mbng_state_t d;

   logic slaveActive;
   logic ownerNic;
   logic asAct;
   logic smackAct;
   logic aleFall;
   logic hostOwns;
   logic hitNow;
   logic masterAle;

   // every decision below reads only the second sync stage
   assign slaveActive = (q.slv != SLV_IDLE);
   assign ownerNic    = !q.nicS2.grantTakenN;
   assign asAct       = !q.nicS2.addrStrobeN;
   assign smackAct    = !q.nicS2.slaveDoneN;
   assign aleFall     = q.alePrev && !q.hostS2.ale;
   assign hostOwns    = q.hostS2.holdGrantN;
   assign hitNow      = (q.hostS2.ad[AD_W-1:WIN_LSB] == windowBase);
   assign masterAle   = (q.mst == MST_ALE);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d        = q;
      // the whole address/data bus is synchronised with its strobes so all
      // pins stay aligned; costs two clocks of latency on each access
      d.hostS1   = hostIn;
      d.hostS2   = q.hostS1;
      d.nicS1    = nicIn;
      d.nicS2    = q.nicS1;
      d.alePrev  = q.hostS2.ale;
      d.captured = 1'b0;

      // register address latch, transparent while host ALE is high
      if (q.hostS2.ale && hostOwns)
      begin
         d.regAddr = q.hostS2.ad[REG_IDX_LSB +: REG_IDX_W];
      end
      if (aleFall && hostOwns)
      begin
         d.captured  = 1'b1;
         d.windowHit = hitNow;
         d.regAddr   = q.hostS2.ad[REG_IDX_LSB +: REG_IDX_W];
      end

      // slave access sequencer
      unique case (q.slv)
         SLV_IDLE:
         begin
            if (q.captured && q.windowHit)
            begin
               d.slv = SLV_SEL;
            end
         end
         SLV_SEL:
         begin
            if (smackAct)
            begin
               d.slv    = SLV_WAIT;
               d.ackCnt = ACK_CNT_START;
               d.isRead = !q.hostS2.rdN;
            end
         end
         SLV_WAIT:
         begin
            if (q.ackCnt == ACK_CNT_LAST)
            begin
               d.slv = SLV_ACK;
            end
            else
            begin
               d.ackCnt = q.ackCnt + 2'h1;
            end
         end
         SLV_ACK:
         begin
            d.slv = SLV_IDLE;
         end
      endcase

      // master access sequencer: start, ALE, data = three clocks per word
      if (!ownerNic || !asAct)
      begin
         d.mst = MST_IDLE;
      end
      else
      begin
         unique case (q.mst)
            MST_IDLE: d.mst = MST_T1;
            MST_T1:   d.mst = MST_ALE;
            MST_ALE:  d.mst = MST_DATA;
            MST_DATA: d.mst = MST_DATA;
         endcase
      end

      // bus request path; grant taken keeps the hold after request drops
      d.holdReq = !q.nicS2.busRequestN || !q.nicS2.grantTakenN;
      d.grantIn = !q.hostS2.holdGrantN;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         q <= STATE_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // host side outputs
   // ----------------------------------------------------------------
   assign hostOut.writeAckN     = !((q.slv == SLV_ACK) && !q.isRead);
   assign hostOut.readValidN    = !((q.slv == SLV_ACK) && q.isRead);
   assign hostOut.holdRequestN  = !q.holdReq;
   assign hostOut.aleOut        = masterAle;
   // data phase on master reads follows the end of ALE
   assign hostOut.dataPhaseOutN = !((q.mst == MST_DATA) && q.nicS2.direction);
   assign hostOut.dataPhaseOe   = ownerNic;
   assign hostOut.rdOutN        = !((q.mst != MST_IDLE) && q.nicS2.direction);
   assign hostOut.wrOutN        = !((q.mst != MST_IDLE) && !q.nicS2.direction);
   assign hostOut.strobeOe      = ownerNic;

   // ----------------------------------------------------------------
   // controller side outputs
   // ----------------------------------------------------------------
   assign nicOut.chipSelN         = !slaveActive;
   assign nicOut.slaveAddrStrobeN = !slaveActive;
   assign nicOut.grantInN         = !q.grantIn;
   assign nicOut.regAddr          = q.regAddr;

   // ----------------------------------------------------------------
   // buffer enables
   // ----------------------------------------------------------------
   assign bufOe.addrToBus = ownerNic && asAct && masterAle;
   assign bufOe.nicToBus  = (slaveActive && !q.hostS2.rdN && !q.hostS2.dataPhaseN)
                          || ((q.mst == MST_DATA) && !q.nicS2.direction);
   assign bufOe.busToNic  = (slaveActive && !q.hostS2.wrN && !q.hostS2.dataPhaseN)
                          || ((q.mst == MST_DATA) && q.nicS2.direction);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence seqSmackSeen;
      (q.slv == SLV_SEL) && smackAct;
   endsequence

   sequence seqAckPulse;
      (!hostOut.writeAckN || !hostOut.readValidN)
      ##1 (hostOut.writeAckN && hostOut.readValidN);
   endsequence

   sequence seqMstStart;
      (q.mst == MST_IDLE) && ownerNic && asAct;
   endsequence

   sequence seqHostHit;
      aleFall && hostOwns && hitNow && (q.slv == SLV_IDLE);
   endsequence

   AST_ACK_DELAY: assert property (seqSmackSeen |-> ##2 seqAckPulse)
      else $error("ack not two clocks after slave done");

   AST_ACK_ONE: assert property ((!hostOut.writeAckN || !hostOut.readValidN)
      |=> (hostOut.writeAckN && hostOut.readValidN))
      else $error("ack held longer than one clock");

   AST_CS_DROP: assert property ((!hostOut.writeAckN || !hostOut.readValidN)
      |=> (nicOut.chipSelN && nicOut.slaveAddrStrobeN))
      else $error("select not dropped with ack");

   AST_CS_FOLLOW: assert property (seqHostHit
      |=> ##1 (!nicOut.chipSelN && !nicOut.slaveAddrStrobeN))
      else $error("select did not follow window hit");

   AST_REG_ADDR: assert property ((aleFall && hostOwns)
      |=> (nicOut.regAddr == $past(q.hostS2.ad[REG_IDX_LSB +: REG_IDX_W])))
      else $error("register address not captured on ALE fall");

   AST_HOLD_REQ: assert property ((!q.nicS2.busRequestN || !q.nicS2.grantTakenN)
      |=> !hostOut.holdRequestN)
      else $error("hold request not raised");

   AST_GRANT: assert property (!q.hostS2.holdGrantN |=> !nicOut.grantInN)
      else $error("grant not passed to controller");

   AST_ALE: assert property (seqMstStart ##1 (ownerNic && asAct) [*2]
      |-> hostOut.aleOut ##1 !hostOut.aleOut)
      else $error("master ALE not in second cycle");

   AST_ADDR_DATA: assert property ((q.mst == MST_DATA) |-> !bufOe.addrToBus)
      else $error("address buffer on in data phase");

   AST_ADDR_OE: assert property (bufOe.addrToBus
      |-> (ownerNic && !q.nicS2.addrStrobeN && (q.mst == MST_ALE)))
      else $error("address buffer enabled out of turn");

   AST_MST_WR_OE: assert property ((!slaveActive && bufOe.nicToBus)
      |-> ($past(hostOut.aleOut) && !hostOut.aleOut) || $past(q.mst == MST_DATA))
      else $error("master write data before ALE fall");

   AST_SLV_RD_OE: assert property ((slaveActive && bufOe.nicToBus)
      |-> !q.hostS2.dataPhaseN)
      else $error("slave read data before data phase");

   AST_STROBE: assert property (seqMstStart |=> (!hostOut.rdOutN || !hostOut.wrOutN))
      else $error("master strobe missing");

   AST_RESET: assert property (@(posedge sys_clk) disable iff (1'b0) rst
      |=> (hostOut.holdRequestN && nicOut.chipSelN && hostOut.writeAckN
           && hostOut.readValidN && !bufOe.nicToBus && !bufOe.busToNic))
      else $error("outputs active during reset");

   // ----------------------------------------------------------------
   // checks: single steps of the slave, request and master paths
   // ----------------------------------------------------------------
   sequence seqHostMiss;
      aleFall && hostOwns && !hitNow && (q.slv == SLV_IDLE);
   endsequence

   sequence seqMstHeld;
      seqMstStart ##1 (ownerNic && asAct) [*2];
   endsequence

   AST_LATCH: assert property ((q.hostS2.ale && hostOwns)
      |=> (nicOut.regAddr == $past(q.hostS2.ad[REG_IDX_LSB +: REG_IDX_W])))
      else $error("register address not following host ALE");

   AST_IDX_STABLE: assert property ((!q.hostS2.ale && !aleFall)
      |=> $stable(nicOut.regAddr))
      else $error("register address moved outside ALE");

   AST_HIT: assert property ((aleFall && hostOwns)
      |=> (q.windowHit == $past(hitNow)))
      else $error("window hit not captured on ALE fall");

   AST_MISS: assert property (seqHostMiss |=> ##1 nicOut.chipSelN)
      else $error("select raised on a window miss");

   AST_WR_ACK: assert property (((q.slv == SLV_SEL) && smackAct && q.hostS2.rdN)
      |-> ##2 !hostOut.writeAckN)
      else $error("write ack missing after slave done");

   AST_RD_ACK: assert property (((q.slv == SLV_SEL) && smackAct && !q.hostS2.rdN)
      |-> ##2 !hostOut.readValidN)
      else $error("read valid missing after slave done");

   AST_SEL_HOLD: assert property ((slaveActive && hostOut.writeAckN && hostOut.readValidN)
      |=> (!nicOut.chipSelN && !nicOut.slaveAddrStrobeN))
      else $error("select dropped before ack");

   AST_HOLD_OFF: assert property ((q.nicS2.busRequestN && q.nicS2.grantTakenN)
      |=> hostOut.holdRequestN)
      else $error("hold request without bus request");

   AST_GRANT_OFF: assert property (q.hostS2.holdGrantN |=> nicOut.grantInN)
      else $error("grant passed without host grant");

   AST_HOST_OWNS: assert property (!ownerNic
      |-> (!bufOe.addrToBus && !hostOut.strobeOe && !hostOut.dataPhaseOe))
      else $error("bus driven without grant taken");

   AST_DMA_WORD: assert property (seqMstHeld |=> (q.mst == MST_DATA))
      else $error("master word not in three clocks");

   AST_ALE_ONE: assert property (hostOut.aleOut |=> !hostOut.aleOut)
      else $error("master ALE longer than one clock");

   AST_STROBE_END: assert property (((q.mst != MST_IDLE) && !asAct)
      |=> (hostOut.rdOutN && hostOut.wrOutN))
      else $error("master strobe held after address strobe");

   AST_RD_DATA: assert property (((q.mst == MST_DATA) && q.nicS2.direction)
      |-> (bufOe.busToNic && !bufOe.nicToBus && !hostOut.dataPhaseOutN))
      else $error("master read data path wrong");

   AST_SLV_WR_OE: assert property ((slaveActive && bufOe.busToNic && (q.mst == MST_IDLE))
      |-> !q.hostS2.dataPhaseN)
      else $error("slave write buffer before data phase");

   AST_BUF_EXCL: assert property (!(bufOe.nicToBus && bufOe.busToNic))
      else $error("both data buffers enabled");

   AST_RESET_IDLE: assert property (@(posedge sys_clk) disable iff (1'b0) rst
      |=> ((q.slv == SLV_IDLE) && (q.mst == MST_IDLE) && !bufOe.addrToBus && !hostOut.aleOut
           && hostOut.rdOutN && hostOut.wrOutN && nicOut.grantInN && nicOut.slaveAddrStrobeN))
      else $error("machines not idle after reset");

endmodule : mbng_glue

`default_nettype wire

// [test/mbng_nic_model.sv]
// controller-side model: slave done answer and dma master cycles
`timescale 1ns/10ps
`default_nettype none

module mbng_nic_model
   import mbng_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          startDma,
   input  wire logic          dmaRead,
   input  wire logic [3:0]    doneDelay,
   input  wire mbng_nic_out_t nicOut,
   output var  mbng_nic_in_t  nicIn
);
   // ------------------------------------------------
   // slave answer, prompt or slow by doneDelay
   // ------------------------------------------------
   initial
   begin
      nicIn = NIC_IN_IDLE;
      forever
      begin
         @(posedge sys_clk);
         if (rst === 1'b0 && nicOut.chipSelN === 1'b0 && nicOut.slaveAddrStrobeN === 1'b0)
         begin
            repeat (doneDelay) @(posedge sys_clk);
            nicIn.slaveDoneN <= 1'b0;
            while (nicOut.chipSelN !== 1'b1)
               @(posedge sys_clk);
            nicIn.slaveDoneN <= 1'b1;
         end
      end
   end

   // ------------------------------------------------
   // dma master: request, wait for grant, one word
   // ------------------------------------------------
   initial
   begin
      forever
      begin
         @(posedge sys_clk);
         if (startDma === 1'b1)
         begin
            nicIn.busRequestN <= 1'b0;
            @(posedge sys_clk);
            // no cycle before grant: the host still owns the bus
            while (nicOut.grantInN !== 1'b0)
               @(posedge sys_clk);
            nicIn.grantTakenN <= 1'b0;
            nicIn.busRequestN <= 1'b1;
            nicIn.direction   <= dmaRead;
            repeat (2) @(posedge sys_clk);
            nicIn.addrStrobeN <= 1'b0;
            repeat (8) @(posedge sys_clk);
            nicIn.addrStrobeN <= 1'b1;
            repeat (4) @(posedge sys_clk);
            nicIn.grantTakenN <= 1'b1;
         end
      end
   end
endmodule : mbng_nic_model
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the multiplexed bus controller glue
`timescale 1ns/10ps
`default_nettype none

module testbench
   import mbng_pkg::*;
;
   logic              sys_clk;
   logic              rst;
   logic [BASE_W-1:0] windowBase;
   mbng_host_in_t     hostIn;
   mbng_nic_in_t      nicIn;
   mbng_host_out_t    hostOut;
   mbng_nic_out_t     nicOut;
   mbng_buf_oe_t      bufOe;
   logic              startDma;
   logic              dmaRead;
   logic [3:0]        doneDelay;
   int                errCount;
   int                testsRun;
   int                cycles = 0;

   mbng_glue i_dut (.sys_clk(sys_clk), .rst(rst), .windowBase(windowBase), .hostIn(hostIn),
      .nicIn(nicIn), .hostOut(hostOut), .nicOut(nicOut), .bufOe(bufOe));

   mbng_nic_model i_nic (.sys_clk(sys_clk), .rst(rst), .startDma(startDma),
      .dmaRead(dmaRead), .doneDelay(doneDelay), .nicOut(nicOut), .nicIn(nicIn));

   // ------------------------------------------------
   // clock, hang guard, helpers
   // ------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // whole run is a few hundred cycles
   always @(posedge sys_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         errCount++;
         endSim();
      end
   end

   task automatic endSim();
      $display("checks %0d, mismatches %0d", testsRun, errCount);
      if (errCount == 0 && testsRun > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : endSim

   task automatic check(input logic ok, input string what);
      testsRun++;
      if (ok !== 1'b1)
      begin
         errCount++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : check

   function automatic logic ackLow(input logic rd);
      return rd ? (hostOut.readValidN === 1'b0) : (hostOut.writeAckN === 1'b0);
   endfunction : ackLow

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic slaveAcc(input logic [AD_W-1:0] addr, input logic rd);
      int k;
      @(posedge sys_clk);
      hostIn.ad  <= addr;
      hostIn.ale <= 1'b1;
      hostIn.rdN <= ~rd;
      hostIn.wrN <= rd;
      @(posedge sys_clk);
      hostIn.ale <= 1'b0;
      for (k = 0; k < 10 && nicOut.chipSelN !== 1'b0; k++)
         @(negedge sys_clk);
      check(nicOut.chipSelN === 1'b0, "no select on hit");
      check(nicOut.slaveAddrStrobeN === 1'b0, "no slave strobe");
      check(nicOut.regAddr === addr[7:2], "register index");
      check(bufOe.nicToBus === 1'b0, "data before data phase");
      @(posedge sys_clk);
      hostIn.dataPhaseN <= 1'b0;
      for (k = 0; k < 20 && nicIn.slaveDoneN !== 1'b0; k++)
         @(negedge sys_clk);
      for (k = 0; k < 8 && !ackLow(rd); k++)
         @(negedge sys_clk);
      check(k == 4, "ack latency");
      check((rd ? hostOut.writeAckN : hostOut.readValidN) === 1'b1, "wrong ack");
      check(bufOe.nicToBus === rd, "read buffer");
      check(bufOe.busToNic === ~rd, "write buffer");
      @(negedge sys_clk);
      check(!ackLow(rd), "ack too long");
      check(nicOut.chipSelN === 1'b1, "select held");
      check(nicOut.slaveAddrStrobeN === 1'b1, "strobe held");
      @(posedge sys_clk);
      hostIn.dataPhaseN <= 1'b1;
      hostIn.rdN        <= 1'b1;
      hostIn.wrN        <= 1'b1;
      repeat (6) @(posedge sys_clk);
      $display("slave test done, addr %h", addr);
   endtask : slaveAcc

   task automatic slaveMiss(input logic [AD_W-1:0] addr);
      logic sel;
      sel = 1'b0;
      @(posedge sys_clk);
      hostIn.ad  <= addr;
      hostIn.ale <= 1'b1;
      @(posedge sys_clk);
      hostIn.ale <= 1'b0;
      repeat (12)
      begin
         @(negedge sys_clk);
         sel = sel | (nicOut.chipSelN !== 1'b1);
      end
      check(sel === 1'b0, "select on miss");
      $display("miss test done, addr %h", addr);
   endtask : slaveMiss

   task automatic dmaAcc(input logic rd);
      int   k;
      logic bad;
      bad = 1'b0;
      @(posedge sys_clk);
      dmaRead  <= rd;
      startDma <= 1'b1;
      @(posedge sys_clk);
      startDma <= 1'b0;
      for (k = 0; k < 8 && hostOut.holdRequestN !== 1'b0; k++)
         @(negedge sys_clk);
      check(k == 4, "hold request latency");
      @(posedge sys_clk);
      hostIn.holdGrantN <= 1'b0;
      for (k = 0; k < 8 && nicOut.grantInN !== 1'b0; k++)
         @(negedge sys_clk);
      check(k == 4, "grant latency");
      for (k = 0; k < 20 && hostOut.aleOut !== 1'b1; k++)
      begin
         @(negedge sys_clk);
         bad = bad | (hostOut.holdRequestN !== 1'b0);
      end
      check(bad === 1'b0, "hold dropped on handover");
      check(hostOut.aleOut === 1'b1, "no master ale");
      check(bufOe.addrToBus === 1'b1, "address not driven");
      check(hostOut.strobeOe === 1'b1, "strobes not owned");
      check(hostOut.dataPhaseOe === 1'b1, "data phase not owned");
      check((rd ? hostOut.rdOutN : hostOut.wrOutN) === 1'b0, "no strobe");
      check(bufOe.nicToBus === 1'b0, "data under ale");
      @(negedge sys_clk);
      check(hostOut.aleOut === 1'b0, "ale too long");
      check(bufOe.addrToBus === 1'b0, "address in data");
      check(bufOe.nicToBus === ~rd, "write data buffer");
      check(bufOe.busToNic === rd, "read data buffer");
      check(hostOut.dataPhaseOutN === ~rd, "data phase out");
      for (k = 0; k < 30 && hostOut.holdRequestN !== 1'b1; k++)
         @(negedge sys_clk);
      check(hostOut.holdRequestN === 1'b1, "hold not released");
      check((hostOut.rdOutN & hostOut.wrOutN) === 1'b1, "strobe held");
      check(bufOe === 3'h0, "buffers left on");
      check((hostOut.dataPhaseOe | hostOut.strobeOe) === 1'b0, "bus not handed back");
      @(posedge sys_clk);
      hostIn.holdGrantN <= 1'b1;
      repeat (6) @(posedge sys_clk);
      $display("dma test done, read %b", rd);
   endtask : dmaAcc

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      rst        = 1'b1;
      hostIn     = HOST_IN_IDLE;
      windowBase = 24'hbf0001;
      startDma   = 1'b0;
      dmaRead    = 1'b0;
      doneDelay  = 4'h1;
      errCount   = 0;
      testsRun   = 0;
      @(negedge sys_clk);
      check(bufOe === 3'h0 && hostOut.aleOut === 1'b0, "reset enables");
      check((hostOut.writeAckN & hostOut.readValidN & hostOut.holdRequestN) === 1'b1,
         "reset host outputs");
      check((nicOut.chipSelN & nicOut.slaveAddrStrobeN & nicOut.grantInN) === 1'b1,
         "reset controller outputs");
      @(posedge sys_clk);
      rst <= 1'b0;
      $display("reset test done");
      slaveAcc(32'hbf0001fc, 1'b1);
      slaveAcc(32'hbf000100, 1'b0);
      slaveMiss(32'hbf000200);
      slaveMiss(32'hbf0000fc);
      @(posedge sys_clk);
      windowBase <= 24'h001234;
      doneDelay  <= 4'h8;
      slaveAcc(32'h00123408, 1'b0);
      slaveAcc(32'h00123400, 1'b1);
      dmaAcc(1'b0);
      dmaAcc(1'b1);
      endSim();
   end
endmodule : testbench
`default_nettype wire
